// ---- rtl/tx_pulse_pkg.sv ----
/*
  Constants, types and the preset sample lookup for the transmit pulse
  template block. Assumes an 8-bit register space with byte offsets.
*/
package tx_pulse_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_TEMPLATE   = 8'h06;
  localparam logic [7:0] ADDR_SCALE      = 8'h07;
  localparam logic [7:0] ADDR_ACCESS     = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE     = 8'h09;
  localparam logic [7:0] ADDR_EVT_MASK   = 8'h15;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h1a;

  // Field positions in the access control and event registers
  localparam int SP_LSB   = 0;
  localparam int UI_LSB   = 4;
  localparam int DIR_BIT  = 6;
  localparam int DONE_BIT = 7;
  localparam int OVF_BIT  = 0;

  // Reset values and scale references
  localparam logic [3:0] TEMPLATE_RST = 4'h0;
  localparam logic [5:0] SCALE_RST    = 6'h21;
  localparam logic [5:0] SCALE_REF_E1 = 6'h21;
  localparam logic [5:0] SCALE_REF_T1 = 6'h36;
  localparam logic [1:0] RAM_MODE     = 2'b11;
  localparam logic [5:0] AMP_MAX      = 6'h3f;

  // Template codes with ROM content
  localparam logic [3:0] TPL_E1_75    = 4'h0;
  localparam logic [3:0] TPL_E1_120   = 4'h1;
  localparam logic [3:0] TPL_T1_SHORT = 4'h2;
  localparam logic [3:0] TPL_J1       = 4'h7;

  localparam logic [6:0] T1_SHORT_UI1 [0:15] = '{
    7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24,
    7'h23, 7'h4a, 7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43};

  typedef enum logic [1:0] {
    G_IDLE  = 2'b00,
    G_FETCH = 2'b01,
    G_LAST  = 2'b11,
    G_OUT   = 2'b10
  } gen_state_t;

  // Preset sample lookup; signed magnitude, sign in bit 6
  function automatic logic [6:0] rom_sample(input logic [3:0] tpl,
                                            input logic [1:0] ui,
                                            input logic [3:0] sp);
    logic [6:0] v;
    v = 7'h00;
    if (tpl == TPL_E1_75 && ui == 2'h0)
      v = (sp == 4'h3) ? 7'h0c
          : ((sp >= 4'h4 && sp <= 4'hb) ? 7'h30 : 7'h00);
    else if (tpl == TPL_E1_120 && ui == 2'h0)
      v = (sp == 4'h3) ? 7'h0f
          : ((sp >= 4'h4 && sp <= 4'hb) ? 7'h3c : 7'h00);
    else if (tpl == TPL_T1_SHORT || tpl == TPL_J1)
    begin
      if (ui == 2'h0)
        v = T1_SHORT_UI1[sp];
      else if (ui == 2'h1 && sp == 4'h0)
        v = 7'h42;
      else if (ui == 2'h1 && sp == 4'h1)
        v = 7'h41;
    end
    return v;
  endfunction

endpackage

// ---- rtl/tx_pulse_template.sv ----
/*
  Transmit pulse template selection, sample memory access and pulse
  summing with amplitude scaling and overflow reporting.
  Assumes register strobes, line marks and ticks come from core_clk logic.
*/
// Behaviour
// - Five T1 cable-length presets chosen by the template select field; the table holds samples only for the shortest, TPL_T1_SHORT.
// - Long-haul attenuation grades 7.5 dB apart, chosen by template select; the table holds no samples for any grade.
// - Template codes 11xx take samples from the user sample memory.
// - Memory holds 4 intervals of 16 sub-phase samples, 64 entries.
// - Samples are 7-bit signed magnitude, +63 down to -63.
// - Twelve standard template codes; the on-chip read-only table has samples for only four (0, 1, 2, 7), the rest output zero.
// - Direction 0 writes the sample field, direction 1 reads the location.
// - The trigger bit performs the access at interval and sample index.
// - Scale steps change amplitude by a line-standard-dependent percentage.
// - Overlap overflow sets a flag; interrupt only when mask enables it.
// - Presets and build-out grades are never scaled.
`timescale 1ns/10ps
module tx_pulse_template
  import tx_pulse_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       line_standard_select,
  input  wire logic       ui_start,
  input  wire logic       mark_pos,
  input  wire logic       mark_neg,
  input  wire logic       subphase_tick,
  output logic      [6:0] dac_code,
  output logic            dac_valid,
  output logic            overflow_irq
);

  logic [3:0] pulse_template_select_r, pulse_template_select_nxt;
  logic [5:0] amplitude_scale_field_r, amplitude_scale_field_nxt;
  logic [3:0] subphase_index_r,        subphase_index_nxt;
  logic [1:0] interval_slot_index_r,   interval_slot_index_nxt;
  logic       dir_r,                   dir_nxt;
  logic       busy_r,                  busy_nxt;
  logic       sw_wait_r,               sw_wait_nxt;
  logic [6:0] sample_amplitude_value_r, sample_amplitude_value_nxt;
  logic       amplitude_overflow_mask_r, amplitude_overflow_mask_nxt;
  logic       amplitude_overflow_flag_r, amplitude_overflow_flag_nxt;
  logic [7:0] rdata_r,                 rdata_nxt;
  logic       irq_r,                   irq_nxt;

  gen_state_t        gst_r,   gst_nxt;
  logic [1:0]        k_r,     k_nxt;
  logic [3:0]        ph_r,    ph_nxt;
  logic [7:0]        hist_r,  hist_nxt;
  logic [1:0]        hsel_r,  hsel_nxt;
  logic signed [9:0] acc_r,   acc_nxt;
  logic [6:0]        rom_q_r, rom_q_nxt;
  logic [6:0]        dac_r,   dac_nxt;
  logic              dval_r,  dval_nxt;

  logic       ram_mode;
  logic       sw_issue;
  logic       ram_we;
  logic [5:0] ram_addr;
  logic [6:0] ram_rdata;
  logic [6:0] smp;
  logic       acc_en;
  logic [8:0] acc_abs;
  logic [14:0] mag_full;
  logic       ovf;

  // User memory mode on the two top select bits
  assign ram_mode = (pulse_template_select_r[3:2] == RAM_MODE);
  // Software waits for an idle generator, so the memory has one user
  assign sw_issue = busy_r && !sw_wait_r && gst_r == G_IDLE
                    && !subphase_tick;
  assign ram_we   = sw_issue && !dir_r;
  assign ram_addr = (gst_r == G_FETCH) ? {k_r, ph_r}
                    : {interval_slot_index_r, subphase_index_r};

  wave_sample_ram #(.AW(6), .DW(7)) u_ram (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .we       (ram_we),
    .addr     (ram_addr),
    .wdata    (sample_amplitude_value_r),
    .rdata    (ram_rdata)
  );

  // Register file and software memory access
  always_comb
  begin
    pulse_template_select_nxt   = pulse_template_select_r;
    amplitude_scale_field_nxt   = amplitude_scale_field_r;
    subphase_index_nxt          = subphase_index_r;
    interval_slot_index_nxt     = interval_slot_index_r;
    dir_nxt                     = dir_r;
    busy_nxt                    = busy_r;
    sw_wait_nxt                 = 1'b0;
    sample_amplitude_value_nxt  = sample_amplitude_value_r;
    amplitude_overflow_mask_nxt = amplitude_overflow_mask_r;
    amplitude_overflow_flag_nxt = amplitude_overflow_flag_r;
    rdata_nxt                   = rdata_r;
    if (reg_wr_en)
    begin
      unique case (reg_addr)
        ADDR_TEMPLATE:
          pulse_template_select_nxt = reg_wdata[3:0];
        ADDR_SCALE:    amplitude_scale_field_nxt = reg_wdata[5:0];
        ADDR_ACCESS:
          if (!busy_r) // Fields frozen while an access is pending
          begin
            subphase_index_nxt      = reg_wdata[SP_LSB +: 4];
            interval_slot_index_nxt = reg_wdata[UI_LSB +: 2];
            dir_nxt                 = reg_wdata[DIR_BIT];
            busy_nxt                = reg_wdata[DONE_BIT];
          end
        ADDR_SAMPLE:   sample_amplitude_value_nxt = reg_wdata[6:0];
        ADDR_EVT_MASK: amplitude_overflow_mask_nxt = reg_wdata[OVF_BIT];
        default: ;
      endcase
    end
    // Write finishes at issue, read one cycle later with the data
    if (sw_issue && !dir_r)
      busy_nxt = 1'b0;
    if (sw_issue && dir_r)
      sw_wait_nxt = 1'b1;
    if (sw_wait_r)
    begin
      sample_amplitude_value_nxt = ram_rdata;
      busy_nxt                   = 1'b0;
    end
    if (reg_rd_en)
    begin
      unique case (reg_addr)
        ADDR_TEMPLATE:   rdata_nxt = {4'h0, pulse_template_select_r};
        ADDR_SCALE:      rdata_nxt = {2'h0, amplitude_scale_field_r};
        ADDR_ACCESS:     rdata_nxt = {busy_r, dir_r, interval_slot_index_r,
                                      subphase_index_r};
        ADDR_SAMPLE:     rdata_nxt = {1'b0, sample_amplitude_value_r};
        ADDR_EVT_MASK:   rdata_nxt = {7'h00, amplitude_overflow_mask_r};
        ADDR_EVT_STATUS: rdata_nxt = {7'h00, amplitude_overflow_flag_r};
        default:         rdata_nxt = 8'h00;
      endcase
      if (reg_addr == ADDR_EVT_STATUS)
        amplitude_overflow_flag_nxt = 1'b0;
    end
    // Set after clear so a same-cycle overflow is never lost
    if (gst_r == G_OUT && ovf)
      amplitude_overflow_flag_nxt = 1'b1;
    irq_nxt = amplitude_overflow_flag_nxt
              && amplitude_overflow_mask_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pulse_template_select_r   <= TEMPLATE_RST;
      amplitude_scale_field_r   <= SCALE_RST;
      subphase_index_r          <= 4'h0;
      interval_slot_index_r     <= 2'h0;
      dir_r                     <= 1'b0;
      busy_r                    <= 1'b0;
      sw_wait_r                 <= 1'b0;
      sample_amplitude_value_r  <= 7'h00;
      amplitude_overflow_mask_r <= 1'b0;
      amplitude_overflow_flag_r <= 1'b0;
      rdata_r                   <= 8'h00;
      irq_r                     <= 1'b0;
    end
    else
    begin
      pulse_template_select_r   <= pulse_template_select_nxt;
      amplitude_scale_field_r   <= amplitude_scale_field_nxt;
      subphase_index_r          <= subphase_index_nxt;
      interval_slot_index_r     <= interval_slot_index_nxt;
      dir_r                     <= dir_nxt;
      busy_r                    <= busy_nxt;
      sw_wait_r                 <= sw_wait_nxt;
      sample_amplitude_value_r  <= sample_amplitude_value_nxt;
      amplitude_overflow_mask_r <= amplitude_overflow_mask_nxt;
      amplitude_overflow_flag_r <= amplitude_overflow_flag_nxt;
      rdata_r                   <= rdata_nxt;
      irq_r                     <= irq_nxt;
    end
  end

  // Sample of the previous fetch, from the table or the memory
  assign smp    = ram_mode ? ram_rdata : rom_q_r;
  assign acc_en = (gst_r == G_FETCH && k_r != 2'h0) || gst_r == G_LAST;
  assign acc_abs = acc_r[9] ? 9'(-acc_r) : acc_r[8:0];
  // Scale only user waveforms; reference depends on line standard
  assign mag_full = ram_mode
    ? (15'(acc_abs) * 15'(amplitude_scale_field_r))
      / 15'(line_standard_select ? SCALE_REF_T1 : SCALE_REF_E1)
    : 15'(acc_abs);
  assign ovf = mag_full > 15'(AMP_MAX);

  // Pulse summing over up to four overlapping intervals
  always_comb
  begin
    gst_nxt   = gst_r;
    k_nxt     = k_r;
    ph_nxt    = ph_r;
    hist_nxt  = hist_r;
    hsel_nxt  = hsel_r;
    acc_nxt   = acc_r;
    rom_q_nxt = rom_q_r;
    dac_nxt   = dac_r;
    dval_nxt  = 1'b0;
    if (acc_en && hsel_r[1] && smp[5:0] != 6'h00)
      acc_nxt = (smp[6] ^ hsel_r[0]) ? acc_r - 10'(smp[5:0])
                                     : acc_r + 10'(smp[5:0]);
    unique case (gst_r)
      G_IDLE:
        if (subphase_tick)
        begin
          gst_nxt = G_FETCH;
          k_nxt   = 2'h0;
          acc_nxt = 10'sh000;
        end
      G_FETCH:
      begin
        rom_q_nxt = rom_sample(pulse_template_select_r, k_r, ph_r);
        hsel_nxt  = hist_r[2*k_r +: 2];
        k_nxt     = k_r + 2'h1;
        if (k_r == 2'h3)
          gst_nxt = G_LAST;
      end
      G_LAST: gst_nxt = G_OUT;
      G_OUT:
      begin
        // Saturate rather than wrap; the flag tells software
        dac_nxt  = {acc_r[9] && acc_r != 10'sh000,
                    ovf ? AMP_MAX : mag_full[5:0]};
        dval_nxt = 1'b1;
        ph_nxt   = ph_r + 4'h1;
        gst_nxt  = G_IDLE;
      end
    endcase
    // New interval restarts the phase and ages the pulse history
    if (ui_start)
    begin
      ph_nxt   = 4'h0;
      hist_nxt = {hist_r[5:0], mark_pos ^ mark_neg, mark_neg & ~mark_pos};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      gst_r   <= G_IDLE;
      k_r     <= 2'h0;
      ph_r    <= 4'h0;
      hist_r  <= 8'h00;
      hsel_r  <= 2'h0;
      acc_r   <= 10'sh000;
      rom_q_r <= 7'h00;
      dac_r   <= 7'h00;
      dval_r  <= 1'b0;
    end
    else
    begin
      gst_r   <= gst_nxt;
      k_r     <= k_nxt;
      ph_r    <= ph_nxt;
      hist_r  <= hist_nxt;
      hsel_r  <= hsel_nxt;
      acc_r   <= acc_nxt;
      rom_q_r <= rom_q_nxt;
      dac_r   <= dac_nxt;
      dval_r  <= dval_nxt;
    end
  end

  assign reg_rdata    = rdata_r;
  assign dac_code     = dac_r;
  assign dac_valid    = dval_r;
  assign overflow_irq = irq_r;

  property p_trigger_done;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(busy_r) |-> ##[1:20] !busy_r;
  endproperty
  a_trigger_done: assert property (p_trigger_done)
    else $error("memory access never completed");

  property p_write_dir;
    @(posedge core_clk) disable iff (!rst_n)
    ram_we |-> busy_r && !dir_r && gst_r == G_IDLE;
  endproperty
  a_write_dir: assert property (p_write_dir)
    else $error("memory written outside a write access");

  property p_read_return;
    @(posedge core_clk) disable iff (!rst_n)
    sw_wait_r |=> sample_amplitude_value_r == $past(ram_rdata) && !busy_r;
  endproperty
  a_read_return: assert property (p_read_return)
    else $error("read data not returned to sample field");

  property p_fetch_addr;
    @(posedge core_clk) disable iff (!rst_n)
    gst_r == G_FETCH |-> ram_addr == {k_r, ph_r} && !ram_we;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr)
    else $error("generator fetch address wrong");

  property p_zero_sample;
    @(posedge core_clk) disable iff (!rst_n)
    acc_en && smp[5:0] == 6'h00 |=> acc_r == $past(acc_r);
  endproperty
  a_zero_sample: assert property (p_zero_sample)
    else $error("zero sample changed the sum");

  property p_preset_unscaled;
    @(posedge core_clk) disable iff (!rst_n)
    gst_r == G_OUT && !ram_mode && acc_abs <= 9'(AMP_MAX)
      |=> dac_r[5:0] == $past(acc_abs[5:0]) && dval_r;
  endproperty
  a_preset_unscaled: assert property (p_preset_unscaled)
    else $error("preset pulse was scaled");

  property p_unit_scale;
    @(posedge core_clk) disable iff (!rst_n)
    gst_r == G_OUT && ram_mode && !line_standard_select
      && amplitude_scale_field_r == SCALE_REF_E1 && acc_abs <= 9'(AMP_MAX)
      |=> dac_r[5:0] == $past(acc_abs[5:0]);
  endproperty
  a_unit_scale: assert property (p_unit_scale)
    else $error("reference scale altered amplitude");

  property p_overflow_flag;
    @(posedge core_clk) disable iff (!rst_n)
    gst_r == G_OUT && ovf |=> amplitude_overflow_flag_r
      && dac_r[5:0] == AMP_MAX ##1 irq_r == amplitude_overflow_mask_r;
  endproperty
  a_overflow_flag: assert property (p_overflow_flag)
    else $error("overflow not flagged or saturated");

  c_sw_read:  cover property (@(posedge core_clk) sw_issue && dir_r);
  c_sw_write: cover property (@(posedge core_clk) ram_we);
  c_overflow: cover property (@(posedge core_clk) $rose(irq_r));
  c_user_out: cover property (@(posedge core_clk) dval_r && ram_mode);

endmodule

// ---- rtl/wave_sample_ram.sv ----
/*
  Single-port waveform sample memory with registered read data.
  Assumes one access per cycle; write and read share the address.
*/
`timescale 1ns/10ps
module wave_sample_ram #(
  parameter int AW = 6,
  parameter int DW = 7
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // Array carries no reset; only the read register does
  always_ff @(posedge core_clk)
  begin
    if (we)
      mem[addr] <= wdata;
    if (!rst_n)
      rdata_r <= '0;
    else
      rdata_r <= mem[addr];
  end

  assign rdata = rdata_r;

endmodule

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the transmit pulse template block: registers,
  sample memory access, preset and user pulse generation, overflow.
  Assumes the design package and the two design modules are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  import tx_pulse_pkg::*;

  logic       core_clk, rst_n, reg_wr_en, reg_rd_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       line_standard_select, ui_start, mark_pos, mark_neg;
  logic       subphase_tick, dac_valid, overflow_irq;
  logic [6:0] dac_code;
  int         errors, cmp_count, hist [4];
  logic [7:0] rd_q [$];
  logic [6:0] dac_q [$];
  logic [6:0] mem [64];
  logic       chk_on, rd_d, ovf_m, msk_m;
  logic [3:0] tpl_m;
  logic [5:0] scl_m;
  logic [7:0] d, exp_rd;
  logic [6:0] exp_dac;
  // Shortest T1 preset, first interval
  logic [6:0] t1_tab [16] = '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25,
    7'h25, 7'h24, 7'h23, 7'h4a, 7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43};

  tx_pulse_template uut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .line_standard_select(line_standard_select), .ui_start(ui_start),
    .mark_pos(mark_pos), .mark_neg(mark_neg),
    .subphase_tick(subphase_tick), .dac_code(dac_code),
    .dac_valid(dac_valid), .overflow_irq(overflow_irq));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read strobe seen at an edge means data is due by the next falling edge
  always @(posedge core_clk) rd_d <= reg_rd_en & chk_on;

  // Monitor: oldest expectation is matched against each result
  always @(negedge core_clk)
  begin
    if (rd_d)
    begin
      exp_rd = rd_q.size() ? rd_q.pop_front() : 8'hxx;
      check(reg_rdata, exp_rd);
    end
    if (dac_valid === 1'b1)
    begin
      exp_dac = dac_q.size() ? dac_q.pop_front() : 7'hxx;
      check(8'(dac_code), 8'(exp_dac));
    end
  end

  // One strobe cycle; the next call always leaves an idle cycle between
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    reg_wr_en = w;
    reg_rd_en = !w;
    reg_addr  = a;
    reg_wdata = v;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    chk_on = 1'b1;
    bus(1'b0, a, 8'h00);
  endtask

  // Busy poll, bounded; a hung access counts as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    chk_on = 1'b0;
    do
    begin
      bus(1'b0, ADDR_ACCESS, 8'h00);
      d = reg_rdata;
      n++;
    end while (d[7] !== 1'b0 && n < 30);
    if (d[7] !== 1'b0)
    begin
      errors++;
      $display("ERROR %0t: memory access never finished", $time);
    end
  endtask

  function automatic logic [6:0] smp(input int k, input int sp);
    if (tpl_m[3:2] == 2'b11)
      return mem[k*16+sp];
    if (tpl_m == 4'h0 && k == 0)
      return (sp == 3) ? 7'h0c : (sp >= 4 && sp <= 11) ? 7'h30 : 7'h00;
    if (tpl_m == 4'h1 && k == 0)
      return (sp == 3) ? 7'h0f : (sp >= 4 && sp <= 11) ? 7'h3c : 7'h00;
    if (tpl_m == 4'h2 || tpl_m == 4'h7)
      return (k == 0) ? t1_tab[sp] : (k == 1 && sp < 2) ? 7'(66 - sp) : 7'h00;
    return 7'h00;
  endfunction

  // Sum of the last four marks; user mode scales the summed magnitude
  // once, so truncation happens after the sum, then it saturates
  function automatic logic [6:0] expect_out(input int sp);
    int acc, mag, rf;
    logic [6:0] v;
    acc = 0;
    rf = line_standard_select ? int'(SCALE_REF_T1) : int'(SCALE_REF_E1);
    for (int k = 0; k < 4; k++)
    begin
      v = smp(k, sp);
      acc += hist[k] * (v[6] ? -int'(v[5:0]) : int'(v[5:0]));
    end
    mag = (acc < 0) ? -acc : acc;
    if (tpl_m[3:2] == 2'b11)
      mag = mag * int'(scl_m) / rf;
    if (mag > 63)
    begin
      ovf_m = 1'b1;
      mag = 63;
    end
    // Sign follows the raw sum, even when scaling leaves no magnitude
    return {acc < 0, 6'(mag)};
  endfunction

  // One unit interval: mark, then sixteen widely spaced sub-phase ticks
  task automatic run_ui(input logic p, input logic n);
    @(posedge core_clk);
    #1;
    ui_start = 1'b1;
    mark_pos = p;
    mark_neg = n;
    @(posedge core_clk);
    #1;
    ui_start = 1'b0;
    mark_pos = 1'b0;
    mark_neg = 1'b0;
    for (int k = 3; k > 0; k--) hist[k] = hist[k-1];
    hist[0] = (p && !n) ? 1 : (n && !p) ? -1 : 0;
    for (int sp = 0; sp < 16; sp++)
    begin
      dac_q.push_back(expect_out(sp));
      @(posedge core_clk);
      #1;
      subphase_tick = 1'b1;
      @(posedge core_clk);
      #1;
      subphase_tick = 1'b0;
      repeat (8) @(posedge core_clk);
    end
  endtask

  task automatic set_cfg(input logic [3:0] t, input logic [5:0] s);
    tpl_m = t;
    scl_m = s;
    bus(1'b1, ADDR_TEMPLATE, {4'($urandom_range(15, 0)), t});
    bus(1'b1, ADDR_SCALE, {2'b11, s});
  endtask

  initial
  begin
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata, ui_start} = '0;
    {line_standard_select, mark_pos, mark_neg, subphase_tick} = '0;
    {errors, cmp_count, chk_on, ovf_m, rst_n} = '0;
    hist = '{0, 0, 0, 0};
    void'($urandom(507));
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // Reset values, unmapped and read-only places
    for (int i = 0; i < 10; i++)
      rd(8'(i), (i == 7) ? 8'h21 : 8'h00);
    rd(ADDR_TEMPLATE, 8'h00);
    rd(ADDR_SCALE, 8'h21);
    rd(ADDR_ACCESS, 8'h00);
    rd(ADDR_EVT_MASK, 8'h00);
    bus(1'b1, ADDR_EVT_STATUS, 8'hff);
    bus(1'b1, 8'h30, 8'hff);
    rd(ADDR_EVT_STATUS, 8'h00);
    rd(8'h30, 8'h00);
    $display("test registers done");
    // Random memory image; -0 at entry 0, full scale at sub-phase 1
    for (int a = 0; a < 64; a++)
    begin
      mem[a] = (a == 0) ? 7'h40 : (a % 16 == 1) ? 7'h3f : 7'($urandom);
      bus(1'b1, ADDR_SAMPLE, {1'b0, mem[a]});
      bus(1'b1, ADDR_ACCESS, {2'b10, 6'(a)});
      wait_idle();
    end
    // Second trigger while a read is in flight must be ignored
    bus(1'b1, ADDR_ACCESS, {2'b11, 6'd5});
    bus(1'b1, ADDR_ACCESS, {2'b10, 6'd9});
    wait_idle();
    rd(ADDR_SAMPLE, {1'b0, mem[5]});
    rd(ADDR_ACCESS, {2'b01, 6'd5});
    for (int a = 63; a >= 0; a--)
    begin
      bus(1'b1, ADDR_ACCESS, {2'b11, 6'(a)});
      wait_idle();
      rd(ADDR_SAMPLE, {1'b0, mem[a]});
    end
    $display("test sample memory done");
    // Every template code; presets take a random scale that must not act
    for (int t = 0; t < 16; t++)
    begin
      // User templates see both line standards, presets a random one
      line_standard_select = (t >= 12) ? 1'(t) : 1'($urandom);
      msk_m = 1'($urandom);
      if (t >= 12)
        set_cfg(4'(t), line_standard_select ? SCALE_REF_T1
                                            : SCALE_REF_E1);
      else
        set_cfg(4'(t), 6'($urandom));
      bus(1'b1, ADDR_EVT_MASK, {7'h7f, msk_m});
      rd(ADDR_EVT_MASK, {7'h00, msk_m});
      run_ui(1'($urandom), 1'($urandom));
      run_ui(1'($urandom), 1'($urandom));
      check({7'h00, overflow_irq}, {7'h00, ovf_m & msk_m});
      rd(ADDR_EVT_STATUS, {7'h00, ovf_m});
      ovf_m = 1'b0;
    end
    $display("test templates done");
    // Forced overlap overflow with the event enabled
    bus(1'b1, ADDR_EVT_MASK, 8'h01);
    repeat (4) run_ui(1'b1, 1'b0);
    check({7'h00, overflow_irq}, 8'h01);
    rd(ADDR_EVT_STATUS, 8'h01);
    repeat (3) @(posedge core_clk);
    check({7'h00, overflow_irq}, 8'h00);
    ovf_m = 1'b0;
    $display("test overflow done");
    // Single isolated pulses so each output has one term to scale
    line_standard_select = 1'b1;
    set_cfg(4'hc, SCALE_REF_T1);
    repeat (4) run_ui(1'b0, 1'b0);
    foreach (hist[i])
    begin
      // One pass against the E1 reference, the rest against T1
      line_standard_select = (i != 2);
      scl_m = (i == 0) ? 6'h36 : (i == 1) ? 6'h00 : 6'($urandom);
      set_cfg(4'hc | 4'(i), scl_m);
      run_ui(i[0], !i[0]);
      repeat (3) run_ui(1'b0, 1'b0);
    end
    rd(ADDR_EVT_STATUS, {7'h00, ovf_m});
    $display("test scaling done");
    repeat (5) @(posedge core_clk);
    if (rd_q.size() != 0 || dac_q.size() != 0)
    begin
      errors++;
      $display("ERROR %0t: expected results never appeared", $time);
    end
    report_and_stop();
  end

  // Watchdog, well beyond the roughly 10000 cycles the tests need
  initial
  begin
    #(60000 * 100);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
